// ==== design/reset_ctrl_pkg.sv ====
package reset_ctrl_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned PIN_LEN_W   = 4;   // Width of pin_assert_length
  localparam int unsigned PULSE_CNT_W = 17;  // Holds 2^16 cycles (length 15)

  // ----------------------------------------------------------------
  // Values after power-up reset
  // ----------------------------------------------------------------
  localparam logic [PIN_LEN_W-1:0] PIN_LEN_RESET       = 4'h0;
  localparam logic                 USER_EN_RESET       = 1'b1;
  localparam logic                 IRQ_EN_RESET        = 1'b0;
  localparam logic                 PIN_DRIVE_LEVEL     = 1'b0;  // Pin is pulled low
  localparam logic                 SYNC_RESET_LEVEL    = 1'b1;  // Pin idles high
  localparam logic [PULSE_CNT_W-1:0] PULSE_CNT_RESET   = 17'h0_0000;

  // ----------------------------------------------------------------
  // Reset state manager states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_POWERUP,
    ST_RUN,
    ST_USER_RST,
    ST_SW_RST
  } rst_state_t;

  // Pin assertion length in slow-clock cycles: 2^(length+1)
  function automatic logic [PULSE_CNT_W-1:0] pulse_cycles(
    input logic [PIN_LEN_W-1:0] len
  );
    logic [PULSE_CNT_W-1:0] one;
    one          = 17'h0_0001;
    // Widen before adding so the longest length does not wrap to zero
    pulse_cycles = one << ({1'b0, len} + 5'h01);
  endfunction

endpackage

// ==== design/pin_pulse_gen.sv ====
`timescale 1ns/1ps
module pin_pulse_gen
  import reset_ctrl_pkg::*;
(
  input  wire logic                            i_clock,   // Slow clock
  input  wire logic                            i_rst,     // Async reset, high
  input  wire logic                            i_req,     // Start a pin pulse
  input  wire logic [reset_ctrl_pkg::PIN_LEN_W-1:0] i_length, // Programmed length
  output logic                                 o_busy     // Pin being driven
);
  import reset_ctrl_pkg::*;

  logic                   busy_q;
  logic [PULSE_CNT_W-1:0] cnt_q;

  // ----------------------------------------------------------------
  // Pulse counter
  // ----------------------------------------------------------------
  // timed pin drive
  // A request while busy is ignored so a pulse is never cut short.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      busy_q <= 1'b0;
      cnt_q  <= PULSE_CNT_RESET;
    end else if (!busy_q) begin
      if (i_req) begin
        busy_q <= 1'b1;
        cnt_q  <= pulse_cycles(i_length) - 17'h0_0001;
      end
    end else if (cnt_q == PULSE_CNT_RESET) begin
      busy_q <= 1'b0;
    end else begin
      cnt_q <= cnt_q - 17'h0_0001;
    end
  end

  assign o_busy = busy_q;

  a_req_starts_drive: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_req && !busy_q) |=> busy_q) else $error("pin pulse did not start");

endmodule

// ==== design/reset_controller_pin_manager.sv ====
`timescale 1ns/1ps
module reset_controller_pin_manager
  import reset_ctrl_pkg::*;
(
  input  wire logic                            i_clock,             // Slow clock
  input  wire logic                            i_rst,               // Power-up reset
  input  wire logic                            i_cfg_write,         // Mode write strobe
  input  wire logic [reset_ctrl_pkg::PIN_LEN_W-1:0] i_pin_assert_length, // New length
  input  wire logic                            i_user_reset_enable, // New enable
  input  wire logic                            i_user_reset_irq_enable, // New irq en
  input  wire logic                            i_sw_reset_req,      // Software reset
  input  wire logic                            i_status_read,       // Status read pulse
  input  wire logic                            i_pin_in,            // Pad level
  output logic                                 o_pin_out,           // Pad drive value
  output logic                                 o_pin_oe,            // Pad drive enable
  output logic                                 o_proc_rst_n,        // Processor reset
  output logic                                 o_watchdog_rst_n,    // Watchdog reset
  output logic                                 o_periph_rst_n,      // Peripheral reset
  output logic [reset_ctrl_pkg::PIN_LEN_W-1:0] o_pin_assert_length, // Mode readback
  output logic                                 o_user_reset_enable, // Mode readback
  output logic                                 o_user_reset_irq_enable, // Readback
  output logic                                 o_pin_level_status,  // Pin level
  output logic                                 o_user_reset_seen_flag, // Sticky flag
  output logic                                 o_user_reset_irq     // Interrupt level
);
  import reset_ctrl_pkg::*;

  logic [PIN_LEN_W-1:0] len_q;
  logic                 user_en_q;
  logic                 irq_en_q;
  logic                 sync1_q;
  logic                 sync2_q;
  logic                 startup_q;
  rst_state_t           state_q;
  rst_state_t           state_d;
  logic                 pin_req;
  logic                 pin_busy;
  logic                 own_drive;
  logic                 ext_low;
  logic                 rst_n_q;
  logic                 flag_q;
  logic                 irq_q;

  // ----------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------
  // only power-up clears
  // Reset only by the power-up reset; the core resets made here never
  // reach it, so settings outlive every processor or software reset.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      len_q     <= PIN_LEN_RESET;
      user_en_q <= USER_EN_RESET;
      irq_en_q  <= IRQ_EN_RESET;
    end else if (i_cfg_write) begin
      len_q     <= i_pin_assert_length;
      user_en_q <= i_user_reset_enable;
      irq_en_q  <= i_user_reset_irq_enable;
    end
  end

  assign o_pin_assert_length     = len_q;
  assign o_user_reset_enable     = user_en_q;
  assign o_user_reset_irq_enable = irq_en_q;

  // ----------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------
  // two-flop sync
  // The pad is asynchronous to the slow clock; only sync2_q is used.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sync1_q <= SYNC_RESET_LEVEL;
      sync2_q <= SYNC_RESET_LEVEL;
    end else begin
      sync1_q <= i_pin_in;
      sync2_q <= sync1_q;
    end
  end

  assign o_pin_level_status = sync2_q;

  // ----------------------------------------------------------------
  // Pin manager
  // ----------------------------------------------------------------
  // drive request
  // One request after power-up, one per accepted software reset.
  assign pin_req = startup_q | ((state_q == ST_RUN) & i_sw_reset_req);

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      startup_q <= 1'b1;
    end else begin
      startup_q <= 1'b0;
    end
  end

  pin_pulse_gen u_pulse (
    .i_clock  (i_clock),
    .i_rst    (i_rst),
    .i_req    (pin_req),
    .i_length (len_q),
    .o_busy   (pin_busy)
  );

  // pin is output only while pulsing
  assign o_pin_out = PIN_DRIVE_LEVEL;
  assign o_pin_oe  = pin_busy;

  // mask own drive
  // The synchroniser lags the pad by two edges, so the pin still reads
  // low just after release; the power-up and software states stay
  // masked until the pin is seen high again.
  assign own_drive = pin_busy | (state_q == ST_POWERUP) | (state_q == ST_SW_RST);
  assign ext_low   = ~sync2_q & ~own_drive;

  // ----------------------------------------------------------------
  // Reset state manager
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_POWERUP: begin
        if (!startup_q && !pin_busy && sync2_q) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (i_sw_reset_req) begin
          state_d = ST_SW_RST;
        end else if (ext_low && user_en_q && !irq_en_q) begin
          state_d = ST_USER_RST;
        end
      end
      ST_USER_RST: begin
        if (sync2_q) begin
          state_d = ST_RUN;
        end
      end
      ST_SW_RST: begin
        if (!pin_busy && sync2_q) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_POWERUP;
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_POWERUP;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rst_n_q <= 1'b0;
    end else begin
      rst_n_q <= (state_d == ST_RUN);
    end
  end

  assign o_proc_rst_n     = rst_n_q;
  assign o_watchdog_rst_n = rst_n_q;
  assign o_periph_rst_n   = rst_n_q;

  // ----------------------------------------------------------------
  // Status flag and interrupt
  // ----------------------------------------------------------------
  // set wins over read
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      flag_q <= 1'b0;
    end else if (ext_low) begin
      flag_q <= 1'b1;
    end else if (i_status_read) begin
      flag_q <= 1'b0;
    end
  end

  assign o_user_reset_seen_flag = flag_q;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_en_q & (flag_q | ext_low) & ~(i_status_read & ~ext_low);
    end
  end

  assign o_user_reset_irq = irq_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  // Helper: length of each pin pulse and length requested for it
  logic [PULSE_CNT_W-1:0] drive_cnt_q;
  logic [PIN_LEN_W-1:0]   req_len_q;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      drive_cnt_q <= PULSE_CNT_RESET;
      req_len_q   <= PIN_LEN_RESET;
    end else begin
      drive_cnt_q <= pin_busy ? drive_cnt_q + 17'h0_0001 : PULSE_CNT_RESET;
      if (pin_req && !pin_busy) begin
        req_len_q <= len_q;
      end
    end
  end

  sequence s_run_ext_low;
    state_q == ST_RUN && !i_sw_reset_req && ext_low;
  endsequence

  a_watchdog_follows: assert property (o_watchdog_rst_n == o_proc_rst_n &&
    o_periph_rst_n == o_proc_rst_n) else $error("reset outputs disagree");
  a_sw_reset_asserts: assert property ((state_q == ST_RUN && i_sw_reset_req)
    |=> !o_proc_rst_n && o_pin_oe) else $error("software reset not applied");
  a_pulse_length: assert property ($fell(o_pin_oe)
    |-> drive_cnt_q == pulse_cycles(req_len_q)) else $error("pin pulse length wrong");
  a_mode_kept: assert property ((!i_cfg_write && !o_proc_rst_n)
    |=> $stable(len_q) && $stable(user_en_q) && $stable(irq_en_q))
    else $error("mode lost in reset");
  a_powerup_hold: assert property ((state_q == ST_POWERUP && !pin_busy && !sync2_q)
    |=> !o_proc_rst_n) else $error("released while pin low");
  a_user_reset: assert property ((s_run_ext_low and user_en_q && !irq_en_q)
    |=> !o_proc_rst_n) else $error("user reset missed");
  a_user_hold: assert property ((state_q == ST_USER_RST && !sync2_q)
    |=> !o_proc_rst_n) else $error("released while pad low");
  a_user_disabled: assert property ((s_run_ext_low and !user_en_q)
    |=> o_proc_rst_n) else $error("disabled user reset fired");
  a_level_status: assert property (i_pin_in [*3] |-> o_pin_level_status)
    else $error("level status stale");
  a_flag_sticky: assert property ((flag_q && !i_status_read) |=> flag_q)
    else $error("seen flag dropped");
  a_irq_not_reset: assert property ((s_run_ext_low and irq_en_q)
    |=> o_proc_rst_n && o_user_reset_irq) else $error("irq mode reset");
  a_own_drive_quiet: assert property ((o_pin_oe && !flag_q) |=> !flag_q)
    else $error("own drive flagged");

endmodule

// ==== test/pin_partner.sv ====
`timescale 1ns/1ps
module pin_partner (
  input  wire logic i_pin_out,  // Device drive value
  input  wire logic i_pin_oe,   // Device drive enable
  input  wire logic i_ext_low,  // Board device pulls low
  output logic      o_pin_level // Resolved pad level
);
  // ----------------------------------------------------------------
  // Pad resolution
  // ----------------------------------------------------------------
  // Wired-and pad with a board pull-up; a released pad rises again
  // outside party holds pad low
  always_comb begin
    o_pin_level = 1'b1;
    if (i_pin_oe && (i_pin_out == 1'b0)) begin
      o_pin_level = 1'b0;
    end
    if (i_ext_low) begin
      o_pin_level = 1'b0;
    end
  end
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import reset_ctrl_pkg::*;
  logic                 clock, rst, cfg_wr, uen, ien, sw_req, st_rd, ext_low;
  logic [PIN_LEN_W-1:0] len;
  logic                 pad, pout, poe, prst_n, wrst_n, rrst_n, uen_q, ien_q, lvl, flag, irq;
  logic [PIN_LEN_W-1:0] len_q;
  int                   fail_count = 0;
  int                   num_checks = 0;

  reset_controller_pin_manager i_dut (
    .i_clock(clock), .i_rst(rst), .i_cfg_write(cfg_wr), .i_pin_assert_length(len),
    .i_user_reset_enable(uen), .i_user_reset_irq_enable(ien), .i_sw_reset_req(sw_req),
    .i_status_read(st_rd), .i_pin_in(pad), .o_pin_out(pout), .o_pin_oe(poe),
    .o_proc_rst_n(prst_n), .o_watchdog_rst_n(wrst_n), .o_periph_rst_n(rrst_n),
    .o_pin_assert_length(len_q), .o_user_reset_enable(uen_q),
    .o_user_reset_irq_enable(ien_q), .o_pin_level_status(lvl),
    .o_user_reset_seen_flag(flag), .o_user_reset_irq(irq));
  pin_partner i_pad (.i_pin_out(pout), .i_pin_oe(poe), .i_ext_low(ext_low), .o_pin_level(pad));

  // ----------------------------------------------------------------
  // Clock, reset and watchdog
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Generous span; the whole sequence needs under a hundred cycles
  initial begin
    #100us;
    fail_count++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic write_cfg(input logic [PIN_LEN_W-1:0] l, input logic e, input logic i);
    cfg_wr = 1'b1;
    len    = l;
    uen    = e;
    ien    = i;
    cyc(1);
    cfg_wr = 1'b0;
    check("len_q", 32'(len_q), 32'(l));
    check("uen_q", 32'(uen_q), 32'(e));
    check("ien_q", 32'(ien_q), 32'(i));
  endtask
  // Counts cycles of pad drive; waits a bounded time for it to start
  task automatic drive_len(output int n);
    int k;
    k = 0;
    n = 0;
    while (poe !== 1'b1 && k < 50) begin
      cyc(1);
      k++;
    end
    while (poe === 1'b1 && n < 1000) begin
      check("pout", 32'(pout), 32'(PIN_DRIVE_LEVEL));
      cyc(1);
      n++;
    end
  endtask
  task automatic wait_run();
    int k;
    k = 0;
    while (prst_n !== 1'b1 && k < 50) begin
      cyc(1);
      k++;
    end
    check("proc_rst_n", 32'(prst_n), 32'h0000_0001);
    check("wdog_rst_n", 32'(wrst_n), 32'h0000_0001);
    check("periph_rst_n", 32'(rrst_n), 32'h0000_0001);
  endtask
  task automatic status_read();
    st_rd = 1'b1;
    cyc(1);
    st_rd = 1'b0;
    cyc(1);
    check("flag clear", 32'(flag), 32'h0000_0000);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_powerup();
    int n;
    check("rst proc", 32'(prst_n), 32'h0000_0000);
    check("rst oe", 32'(poe), 32'h0000_0000);
    check("rst lvl", 32'(lvl), 32'h0000_0001);
    check("rst len", 32'(len_q), 32'(PIN_LEN_RESET));
    check("rst uen", 32'(uen_q), 32'(USER_EN_RESET));
    rst = 1'b0;
    drive_len(n);
    check("powerup drive", 32'(n), 32'h0000_0002);
    wait_run();
    check("no self flag", 32'(flag), 32'h0000_0000);
  endtask
  // Longer length on a software request; the length must survive the reset
  task automatic t_sw_reset();
    int n;
    write_cfg(4'h2, 1'b1, 1'b0);
    sw_req = 1'b1;
    cyc(1);
    sw_req = 1'b0;
    check("sw proc", 32'(prst_n), 32'h0000_0000);
    check("sw wdog", 32'(wrst_n), 32'h0000_0000);
    check("sw periph", 32'(rrst_n), 32'h0000_0000);
    check("sw oe", 32'(poe), 32'h0000_0001);
    drive_len(n);
    check("sw drive", 32'(n), 32'h0000_0008);
    wait_run();
    check("sw flag", 32'(flag), 32'h0000_0000);
    check("len kept", 32'(len_q), 32'h0000_0002);
  endtask
  task automatic t_user_reset();
    ext_low = 1'b1;
    cyc(1);
    check("sync stage", 32'(lvl), 32'h0000_0001);
    cyc(2);
    check("lvl low", 32'(lvl), 32'h0000_0000);
    cyc(2);
    check("seen", 32'(flag), 32'h0000_0001);
    cyc(20);
    check("held", 32'(prst_n), 32'h0000_0000);
    ext_low = 1'b0;
    wait_run();
    check("sticky", 32'(flag), 32'h0000_0001);
    status_read();
  endtask
  // Low pad with a given mode: reset must stay off, flag and irq as set
  task automatic t_no_reset(input logic i);
    write_cfg(4'h0, i, i);
    ext_low = 1'b1;
    cyc(8);
    check("proc up", 32'(prst_n), 32'h0000_0001);
    check("flag", 32'(flag), 32'h0000_0001);
    check("irq", 32'(irq), 32'(i));
    ext_low = 1'b0;
    // The synchroniser still shows low for two edges, and a set beats a read
    cyc(2);
    status_read();
    check("irq off", 32'(irq), 32'h0000_0000);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst     = 1'b1;
    cfg_wr  = 1'b0;
    len     = 4'h0;
    uen     = 1'b1;
    ien     = 1'b0;
    sw_req  = 1'b0;
    st_rd   = 1'b0;
    ext_low = 1'b0;
    cyc(10);
    t_powerup();
    t_sw_reset();
    t_user_reset();
    t_no_reset(1'b0);
    t_no_reset(1'b1);
    tally_and_finish();
  end

  task automatic tally_and_finish();
    if (fail_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
endmodule
